//--- src/uir_pkg.sv
// Constants for the serial interrupt-sharing configuration block.
// Assumes a byte-addressed AXI4-Lite register space, one 32-bit word per register.
package uir_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] MODE_OFS    = 8'hf0;
    localparam logic [7:0] STAT_OFS    = 8'h00;
    localparam logic [7:0] MASK_OFS    = 8'h04;
    localparam logic [7:0] PIN_OFS     = 8'h08;
    // ==========================================================
    // Field positions
    localparam int         MODE_MIDI_BIT  = 0;
    localparam int         MODE_HS_BIT    = 1;
    localparam int         MODE_SHARE_BIT = 7;
    localparam int         MCR_AUX_BIT    = 2;
    localparam int         STAT_W         = 2;
    // ==========================================================
    // Reset values and bus answers
    localparam logic [7:0] MODE_RST    = 8'h00;
    localparam logic [7:0] MODE_KEEP   = 8'h83;
    localparam logic [1:0] STAT_RST    = 2'h0;
    localparam logic [1:0] MASK_RST    = 2'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uir_pkg

//--- src/uir_irq_route.sv
// Combines two serial channels' requests onto their interrupt pins.
// Assumes requests and auxiliary gating bits come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module uir_irq_route (
    // Channel requests and gating
    input  wire logic req1,
    input  wire logic req2,
    input  wire logic aux1,
    input  wire logic aux2,
    input  wire logic share,
    // Pin drive and enable
    output logic      drv1,
    output logic      oe1,
    output logic      drv2,
    output logic      oe2
);
    logic anyReq;

    // ==========================================================
    // Pin combining
    always_comb begin
        anyReq = (aux1 & req1) | (aux2 & req2);
        if (share) begin
            oe1  = aux1 | aux2;
            oe2  = aux1 | aux2;
            drv1 = anyReq;
            drv2 = anyReq;
        end else begin
            oe1  = aux1;
            oe2  = aux2;
            drv1 = aux1 & req1;
            drv2 = aux2 & req2;
        end
    end
endmodule : uir_irq_route
`default_nettype wire

//--- src/uir_top.sv
// Mode register and interrupt pin routing for two serial channels, AXI4-Lite slave.
// Assumes channel requests and modem control bytes arrive from logic on clk.
`timescale 1ns/100ps
`default_nettype none
module uir_top
    import uir_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Serial channel requests and modem control
    input  wire logic              firstChanReq,
    input  wire logic              secondChanReq,
    input  wire logic [7:0]        firstModemCtrl,
    input  wire logic [7:0]        secondModemCtrl,
    // Interrupt pins
    output logic                   firstIrqOut,
    output logic                   firstIrqOe,
    output logic                   secondIrqOut,
    output logic                   secondIrqOe,
    // Mode outputs and summary interrupt
    output logic                   midiEnable,
    output logic                   highSpeedEnable,
    output logic                   shareIrq,
    output logic                   irq
);
    // ==========================================================
    // Parameter check, refused at elaboration: the decoder needs byte offsets up to 0xf0
    if (ADDR_W < 8) begin : g_addrWidthCheck
        $error("uir_top: ADDR_W must be at least 8");
    end

    // ==========================================================
    // Declarations
    logic              awReady_q, awReady_d, wReady_q, wReady_d;
    logic              bValid_q, bValid_d, arReady_q, arReady_d;
    logic              rValid_q, rValid_d;
    logic [1:0]        bResp_q, bResp_d, rResp_q, rResp_d;
    logic [31:0]       rData_q, rData_d, wData_q, wData_d;
    logic [3:0]        wStrb_q, wStrb_d;
    logic [7:0]        awAddr_q, awAddr_d;
    logic [7:0]        mode_q, mode_d;
    logic [STAT_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [1:0]        reqPrev_q;
    logic              irq_q, irq_d;
    logic              pinDrv1, pinOe1, pinDrv2, pinOe2;
    logic              pinDrv1_q, pinOe1_q, pinDrv2_q, pinOe2_q;
    logic              doWrite, wrHit;
    logic [7:0]        rdAddr;
    logic [STAT_W-1:0] events;

    // ==========================================================
    // Interrupt pin combining
    uir_irq_route u_route (
        .req1  (firstChanReq),
        .req2  (secondChanReq),
        .aux1  (firstModemCtrl[MCR_AUX_BIT]),
        .aux2  (secondModemCtrl[MCR_AUX_BIT]),
        .share (mode_q[MODE_SHARE_BIT]),
        .drv1  (pinDrv1),
        .oe1   (pinOe1),
        .drv2  (pinDrv2),
        .oe2   (pinOe2)
    );

    // ==========================================================
    // Write channel: address and data taken in either order
    always_comb begin
        awReady_d = awReady_q;
        wReady_d  = wReady_q;
        awAddr_d  = awAddr_q;
        wData_d   = wData_q;
        wStrb_d   = wStrb_q;
        bValid_d  = bValid_q;
        bResp_d   = bResp_q;
        doWrite   = 1'b0;
        wrHit     = 1'b0;
        if (s_axi_awvalid && awReady_q) begin
            awAddr_d  = s_axi_awaddr[7:0];
            awReady_d = 1'b0;
        end
        if (s_axi_wvalid && wReady_q) begin
            wData_d  = s_axi_wdata;
            wStrb_d  = s_axi_wstrb;
            wReady_d = 1'b0;
        end
        if (!awReady_q && !wReady_q && !bValid_q) begin
            doWrite  = 1'b1;
            wrHit    = (awAddr_q == MODE_OFS) || (awAddr_q == STAT_OFS)
                    || (awAddr_q == MASK_OFS) || (awAddr_q == PIN_OFS);
            bValid_d = 1'b1;
            bResp_d  = wrHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (bValid_q && s_axi_bready) begin
            bValid_d  = 1'b0;
            awReady_d = 1'b1;
            wReady_d  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            awReady_q <= 1'b1;
            wReady_q  <= 1'b1;
            awAddr_q  <= 8'h00;
            wData_q   <= 32'h0000_0000;
            wStrb_q   <= 4'h0;
            bValid_q  <= 1'b0;
            bResp_q   <= RESP_OKAY;
        end else begin
            awReady_q <= awReady_d;
            wReady_q  <= wReady_d;
            awAddr_q  <= awAddr_d;
            wData_q   <= wData_d;
            wStrb_q   <= wStrb_d;
            bValid_q  <= bValid_d;
            bResp_q   <= bResp_d;
        end
    end

    // ==========================================================
    // Mode, status and mask registers
    always_comb begin
        mode_d = mode_q;
        mask_d = mask_q;
        stat_d = stat_q;
        events = {secondChanReq & ~reqPrev_q[1], firstChanReq & ~reqPrev_q[0]};
        if (doWrite && wStrb_q[0]) begin
            if (awAddr_q == MODE_OFS) begin
                mode_d = wData_q[7:0] & MODE_KEEP;
            end
            if (awAddr_q == MASK_OFS) begin
                mask_d = wData_q[STAT_W-1:0];
            end
            if (awAddr_q == STAT_OFS) begin
                stat_d = stat_q & ~wData_q[STAT_W-1:0];
            end
        end
        stat_d = stat_d | events;                    // Set wins over clear
        irq_d  = |(stat_d & mask_d);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q    <= MODE_RST;
            mask_q    <= MASK_RST;
            stat_q    <= STAT_RST;
            reqPrev_q <= 2'h0;
            irq_q     <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            mask_q    <= mask_d;
            stat_q    <= stat_d;
            reqPrev_q <= {secondChanReq, firstChanReq};
            irq_q     <= irq_d;
        end
    end

    // ==========================================================
    // Read channel: one cycle after the address is taken
    always_comb begin
        arReady_d = arReady_q;
        rValid_d  = rValid_q;
        rData_d   = rData_q;
        rResp_d   = rResp_q;
        rdAddr    = s_axi_araddr[7:0];
        if (s_axi_arvalid && arReady_q) begin
            arReady_d = 1'b0;
            rValid_d  = 1'b1;
            rResp_d   = RESP_OKAY;
            rData_d   = 32'h0000_0000;
            case (rdAddr)
                MODE_OFS: rData_d[7:0]        = mode_q;
                STAT_OFS: rData_d[STAT_W-1:0] = stat_q;
                MASK_OFS: rData_d[STAT_W-1:0] = mask_q;
                PIN_OFS:  rData_d[3:0]        = {pinOe2_q, pinDrv2_q, pinOe1_q, pinDrv1_q};
                default:  rResp_d             = RESP_SLVERR;
            endcase
        end
        if (rValid_q && s_axi_rready) begin
            rValid_d  = 1'b0;
            arReady_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            arReady_q <= 1'b1;
            rValid_q  <= 1'b0;
            rData_q   <= 32'h0000_0000;
            rResp_q   <= RESP_OKAY;
        end else begin
            arReady_q <= arReady_d;
            rValid_q  <= rValid_d;
            rData_q   <= rData_d;
            rResp_q   <= rResp_d;
        end
    end

    // ==========================================================
    // Pin registers, one cycle behind the combining logic
    always_ff @(posedge clk) begin
        if (reset) begin
            pinDrv1_q <= 1'b0;
            pinOe1_q  <= 1'b0;
            pinDrv2_q <= 1'b0;
            pinOe2_q  <= 1'b0;
        end else begin
            pinDrv1_q <= pinDrv1;
            pinOe1_q  <= pinOe1;
            pinDrv2_q <= pinDrv2;
            pinOe2_q  <= pinOe2;
        end
    end

    // ==========================================================
    // Output assignments
    assign s_axi_awready   = awReady_q;
    assign s_axi_wready    = wReady_q;
    assign s_axi_bvalid    = bValid_q;
    assign s_axi_bresp     = bResp_q;
    assign s_axi_arready   = arReady_q;
    assign s_axi_rvalid    = rValid_q;
    assign s_axi_rdata     = rData_q;
    assign s_axi_rresp     = rResp_q;
    assign firstIrqOut     = pinDrv1_q;
    assign firstIrqOe      = pinOe1_q;
    assign secondIrqOut    = pinDrv2_q;
    assign secondIrqOe     = pinOe2_q;
    assign midiEnable      = mode_q[MODE_MIDI_BIT];
    assign highSpeedEnable = mode_q[MODE_HS_BIT];
    assign shareIrq        = mode_q[MODE_SHARE_BIT];
    assign irq             = irq_q;
endmodule : uir_top
`default_nettype wire

//--- verif/uir_top_chk.sv
// Checker for interrupt pin combining, mode reset and bus answers of uir_top.
// Assumes it is bound to uir_top, one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module uir_top_chk
    import uir_pkg::*;
(
    // Clock, reset and bus handshakes
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    // Channels, pins and mode outputs
    input wire logic       firstChanReq,
    input wire logic       secondChanReq,
    input wire logic [7:0] firstModemCtrl,
    input wire logic [7:0] secondModemCtrl,
    input wire logic       firstIrqOut,
    input wire logic       firstIrqOe,
    input wire logic       secondIrqOut,
    input wire logic       secondIrqOe,
    input wire logic       midiEnable,
    input wire logic       highSpeedEnable,
    input wire logic       shareIrq
);
    // ==========================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire logic aux1 = firstModemCtrl[MCR_AUX_BIT];
    wire logic aux2 = secondModemCtrl[MCR_AUX_BIT];
    wire logic act1 = aux1 & firstChanReq;
    wire logic act2 = aux2 & secondChanReq;
    // Sharing bit steady over three samples, so pins saw one mode
    sequence calm;
        !$past(reset) && $past(shareIrq) == shareIrq && $past(shareIrq, 2) == shareIrq;
    endsequence
    sequence wrBoth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sep_oe_a: assert property (calm ##0 !shareIrq |->
        firstIrqOe == $past(aux1) && secondIrqOe == $past(aux2)) else $error("pin enable wrong");
    sep_out_a: assert property (calm ##0 !shareIrq |->
        firstIrqOut == $past(act1) && secondIrqOut == $past(act2)) else $error("pin level wrong");
    share_oe_a: assert property (calm ##0 shareIrq |->
        firstIrqOe == ($past(aux1) || $past(aux2)) && secondIrqOe == firstIrqOe)
        else $error("shared enable wrong");
    share_out_a: assert property (calm ##0 shareIrq ##0 firstIrqOe |->
        firstIrqOut == ($past(act1) || $past(act2)) && secondIrqOut == firstIrqOut)
        else $error("shared level wrong");
    mode_rst_a: assert property ($fell(reset) |->
        !midiEnable && !highSpeedEnable && !shareIrq) else $error("mode not cleared");
    wr_answer_a: assert property (wrBoth |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
endmodule : uir_top_chk
bind uir_top uir_top_chk i_uir_top_chk (.*);
`default_nettype wire

//--- verif/uir_host_model.sv
// Host side of the two interrupt lines: resolves each line from pin drive.
// Assumes no pull on the lines; a released line shows a changing level.
`timescale 1ns/100ps
`default_nettype none
module uir_host_model (
    // Clock and pin drive
    input  wire logic clk,
    input  wire logic out1,
    input  wire logic oe1,
    input  wire logic modem_aux_output_bit,
    input  wire logic oe2,
    // Resolved lines
    output logic      line1,
    output logic      line2
);
    // A released line toggles every cycle so no stale value is read
    logic last1_q = 1'b0;
    logic last2_q = 1'b0;
    assign line1 = oe1 ? out1 : ~last1_q;
    assign line2 = oe2 ? modem_aux_output_bit : ~last2_q;
    always_ff @(posedge clk) begin
        last1_q <= line1;
        last2_q <= line2;
    end
endmodule : uir_host_model
`default_nettype wire

//--- verif/tb_uart_irq_sharing_config.sv
// Bench for uir_top: registers over AXI4-Lite, interrupt pins, status and mask.
// Assumes a 100 MHz clock; the host model resolves the interrupt lines.
`timescale 1ns/100ps
`default_nettype none
module tb_uart_irq_sharing_config
    import uir_pkg::*;
;
    logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, firstModemCtrl, secondModemCtrl;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic firstChanReq, secondChanReq, firstIrqOut, firstIrqOe, secondIrqOut, secondIrqOe;
    logic midiEnable, highSpeedEnable, shareIrq, irq, line1, line2, e1, o1, e2, o2;
    int mismatches, comparisons, cycles;
    // ==========================================
    // Clock, timeout and instances
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    uir_top i_uir_top (.*);
    uir_host_model i_uir_host_model (.clk(clk), .out1(firstIrqOut), .oe1(firstIrqOe),
        .modem_aux_output_bit(secondIrqOut), .oe2(secondIrqOe), .line1(line1), .line2(line2));
    // Compare and count
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Bus write, each channel released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        cmp(s_axi_bresp, r);
    endtask : wr
    // Bus read
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        cmp(s_axi_rdata, d);
        cmp(s_axi_rresp, r);
    endtask : rd
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // ==========================================
    // Main sequence
    initial begin
        {clk, reset, s_axi_bready, s_axi_rready} = 4'h7;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, firstChanReq, secondChanReq} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, firstModemCtrl, secondModemCtrl} = 32'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(MODE_OFS, 32'h0, RESP_OKAY);
        rd(STAT_OFS, 32'h0, RESP_OKAY);
        rd(MASK_OFS, 32'h0, RESP_OKAY);
        for (int m = 1; m < 3; m++) begin
            wr(MODE_OFS, 32'(m), RESP_OKAY);
            @(posedge clk);
            cmp({midiEnable, highSpeedEnable}, {m[0], m[1]});
            rd(MODE_OFS, 32'(m), RESP_OKAY);
        end
        wr(MODE_OFS, 32'h0, RESP_OKAY);
        // Every gating, request and sharing combination; other modem bits set while gating is off
        for (int i = 0; i < 32; i++) begin
            if (i == 16) begin
                firstModemCtrl <= 8'h04;
                secondModemCtrl <= 8'h00;
                @(posedge clk);
                wr(MODE_OFS, 32'h80, RESP_OKAY);
            end
            firstModemCtrl <= i[3] ? 8'h04 : 8'hfb;
            firstChanReq <= i[2];
            secondModemCtrl <= i[1] ? 8'h04 : 8'hfb;
            secondChanReq <= i[0];
            e1 = i[4] ? i[3] | i[1] : i[3];
            e2 = i[4] ? e1 : i[1];
            o1 = i[4] ? (i[3] & i[2]) | (i[1] & i[0]) : i[3] & i[2];
            o2 = i[4] ? o1 : i[1] & i[0];
            repeat (2) @(posedge clk);
            cmp({firstIrqOe, firstIrqOut, secondIrqOe, secondIrqOut}, {e1, o1, e2, o2});
            if (e1) cmp(line1, o1);
            if (e2) cmp(line2, o2);
        end
        cmp(shareIrq, 1'b1);
        rd(PIN_OFS, 32'hf, RESP_OKAY);
        // Byte lane 0 off: the mode write is ignored but still answered OKAY
        s_axi_wstrb <= 4'he;
        wr(MODE_OFS, 32'h1, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(MODE_OFS, 32'h80, RESP_OKAY);
        cmp(midiEnable, 1'b0);
        // Pin word is read-only: a write is answered and changes nothing
        wr(PIN_OFS, 32'h0, RESP_OKAY);
        rd(PIN_OFS, 32'hf, RESP_OKAY);
        rd(STAT_OFS, 32'h3, RESP_OKAY);
        cmp(irq, 1'b0);
        wr(MASK_OFS, 32'h1, RESP_OKAY);
        @(posedge clk);
        cmp(irq, 1'b1);
        wr(STAT_OFS, 32'h1, RESP_OKAY);
        @(posedge clk);
        cmp(irq, 1'b0);
        rd(STAT_OFS, 32'h2, RESP_OKAY);
        wr(8'h40, 32'h1, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(MODE_OFS, 32'h0, RESP_OKAY);
        tally_and_finish();
    end
endmodule : tb_uart_irq_sharing_config
`default_nettype wire
